// [verilog/uart_irq_fifo_line_control.sv]
// Purpose: Interrupt source encoder, FIFO control and character format for one UART channel
// Assumes: Data path, FIFOs and status registers live outside and report through ports
// Notes:   Zero wait state AHB-Lite slave, read data registered in the address phase
// Operation
// - Line status interrupt raised when any line status error bit 1..4 sets.
// - Time-out interrupt after four character times plus twelve bit times idle.
// - Transmit ready interrupt from transmit trigger level or transmit FIFO empty.
// - Modem status interrupt raised when any modem change bit 0..3 sets.
// - Flow interrupt on CTS# or RTS# rising edge during automatic flow control.
// - Reading line status register clears the line status interrupt.
// - Receive ready clears only when occupancy drops below trigger level.
// - Reading receive holding register clears the time-out interrupt.
// - Interrupt status read or transmit holding write clears transmit ready.
// - Modem status read clears modem and flow change interrupts.
// - Xoff clears on status read or Xon; special on status read or next char.
// - Seven priority levels, only the highest pending source reported.
// - Status bits 5..0 carry the source code, 000001 when nothing pending.
// - Status bits 7:6 read one while FIFOs enabled, else zero.
// - Status bits 4 and 5 report only with enhanced bit 4 set.
// - FIFO control bits ignored unless bit 0 written one; bit 0 zero disables.
// - FIFO reset bits pulse pointer resets once, only with FIFOs enabled.
// - Transmit trigger 1/4/8/14, writable only with enhanced bit 4 set.
// - Receive trigger 1/4/8/14 sets the receive interrupt threshold.
// - Line control bits 1:0 select 5 to 8 bit words, 5 after reset.
// - Bit 2 clear gives one stop bit, else 1.5 for 5-bit or two stops.
// - Bit 3 enables parity, bit 4 selects odd when 0, even when 1.
// - Overrun sets at once; bits 2..4 when errored char reaches the top.
`timescale 1ns/1ns
module uart_irq_fifo_line_control
  import uart_irq_line_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic        hwrite,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Status from the surrounding UART
  input  wire logic [7:0]  rx_data,
  input  wire logic [7:0]  line_status,
  input  wire logic [7:0]  modem_status,
  input  wire logic [7:0]  ier,
  input  wire logic [4:0]  rx_count,
  input  wire logic [4:0]  tx_count,
  input  wire logic        bit_tick,
  input  wire rx_evt_t     rx_evt,
  input  wire logic        cts_n,
  input  wire logic        rts_n_state,
  // Controls to the surrounding UART
  output logic [7:0]       tx_data,
  output logic             tx_write,
  output logic             rx_read,
  output fifo_ctl_t        fifo_ctl,
  output logic             rx_fifo_reset,
  output logic             tx_fifo_reset,
  output line_fmt_t        line_fmt,
  output logic [7:0]       enhanced_feature_reg,
  output logic             int_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        acc;
  logic        rd_acc;
  logic        wr_acc;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        lsr_rd;
  logic        msr_rd;
  logic        isr_rd;
  logic        rhr_rd;
  logic        wr_now;
  logic [7:0]  wdat;
  logic [5:0]  isr_code;
  logic [7:0]  isr_val;
  logic [7:0]  rd_mux;
  line_fmt_t   lcr_r;
  fifo_ctl_t   fcr_r;
  logic [7:0]  efr_r;
  logic        rxrst_r;
  logic        txrst_r;
  logic [7:0]  txd_r;
  logic        txw_r;

  // Only whole-word writes take effect; other writes complete harmlessly, reads of any size act
  assign acc       = hsel & htrans[1] & hready;
  assign rd_acc    = acc & ~hwrite;
  assign wr_acc    = acc & hwrite & (hsize == SIZE_WORD);
  assign lsr_rd    = rd_acc & (haddr == OFS_LSR);
  assign msr_rd    = rd_acc & (haddr == OFS_MSR);
  assign isr_rd    = rd_acc & (haddr == OFS_ISR);
  assign rhr_rd    = rd_acc & (haddr == OFS_DATA);
  assign wr_now    = wr_pend_r;
  assign wdat      = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Write address captured in the address phase, data used in the data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= wr_acc;
      wr_addr_r <= haddr;
    end

  // Read data mux; unmapped offsets read as zero
  always_comb
  begin
    case (haddr)
      OFS_DATA: rd_mux = rx_data;
      OFS_ISR:  rd_mux = isr_val;
      OFS_LCR:  rd_mux = lcr_r;
      OFS_LSR:  rd_mux = line_status;
      OFS_MSR:  rd_mux = modem_status;
      OFS_EFR:  rd_mux = efr_r;
      default:  rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_acc)
      hrdata <= {24'h00_0000, rd_mux};

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Line format register, decoded by the transmitter and receiver
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      lcr_r <= LCR_RST;
    else if (wr_now && wr_addr_r == OFS_LCR)
      lcr_r <= wdat;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      efr_r <= EFR_RST;
    else if (wr_now && wr_addr_r == OFS_EFR)
      efr_r <= wdat;

  // FIFO control: a write without the enable bit only disables the FIFOs
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      fcr_r <= '0;
    else if (wr_now && wr_addr_r == OFS_ISR)
    begin
      if (wdat[FCR_EN_BIT])
      begin
        fcr_r.en      <= 1'b1;
        fcr_r.dma     <= wdat[FCR_DMA_BIT];
        fcr_r.rx_trig <= wdat[7:6];
        if (efr_r[EFR_ENH_BIT])
          fcr_r.tx_trig <= wdat[5:4];
      end
      else
        fcr_r.en <= 1'b0;
    end

  // Pointer reset strobes last one cycle, so the bits read back as zero
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rxrst_r <= 1'b0;
      txrst_r <= 1'b0;
    end
    else
    begin
      rxrst_r <= wr_now && wr_addr_r == OFS_ISR && wdat[FCR_EN_BIT] && wdat[FCR_RXRST_BIT];
      txrst_r <= wr_now && wr_addr_r == OFS_ISR && wdat[FCR_EN_BIT] && wdat[FCR_TXRST_BIT];
    end

  // Transmit holding write strobe and data
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      txw_r <= 1'b0;
      txd_r <= 8'h00;
    end
    else
    begin
      txw_r <= wr_now && wr_addr_r == OFS_DATA;
      if (wr_now && wr_addr_r == OFS_DATA)
        txd_r <= wdat;
    end

  assign line_fmt      = lcr_r;
  assign fifo_ctl      = fcr_r;
  assign enhanced_feature_reg           = efr_r;
  assign rx_fifo_reset = rxrst_r;
  assign tx_fifo_reset = txrst_r;
  assign tx_write      = txw_r;
  assign tx_data       = txd_r;
  assign rx_read       = rhr_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger levels and receive ready

  function automatic logic [4:0] trig_lvl(input logic [1:0] code);
    case (code)
      2'b00:   trig_lvl = TRIG_L0;
      2'b01:   trig_lvl = TRIG_L1;
      2'b10:   trig_lvl = TRIG_L2;
      default: trig_lvl = TRIG_L3;
    endcase
  endfunction : trig_lvl

  logic [4:0] rx_lvl;
  logic [4:0] tx_lvl;
  logic       rx_ready_event;

  // Non-FIFO mode behaves as a one-deep FIFO with level one
  assign rx_lvl = fcr_r.en ? trig_lvl(fcr_r.rx_trig) : TRIG_L0;
  assign tx_lvl = fcr_r.en ? trig_lvl(fcr_r.tx_trig) : TRIG_L0;
  // Level term: drops by itself once reads take occupancy below the level
  assign rx_ready_event = (rx_count >= rx_lvl);

  ////////////////////////////////////////////////////////////////////////////
  // Receive time-out timer

  logic [3:0] char_bits;
  logic [6:0] to_limit;
  logic [6:0] to_cnt_r;
  logic       to_flag_r;
  logic       to_restart;
  logic       to_hit;

  // Start + data + parity + stop; 1.5 stops round up to two bit times
  assign char_bits  = START_PLUS_5 + {2'b00, lcr_r.wlen} + {3'b000, lcr_r.par_en}
                    + (lcr_r.stop2 ? 4'h2 : 4'h1);
  assign to_limit   = 7'(TO_CHARS * {3'b000, char_bits}) + TO_EXTRA_BITS;
  assign to_restart = rx_evt.push | rhr_rd | (rx_count == 5'h00);
  assign to_hit     = bit_tick & ~to_restart & ~to_flag_r & (to_cnt_r == to_limit - 7'h01);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      to_cnt_r <= 7'h00;
    else if (to_restart)
      to_cnt_r <= 7'h00;
    else if (bit_tick && !to_flag_r)
      to_cnt_r <= to_cnt_r + 7'h01;

  // A host read restarts the timer, so set and clear never coincide
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      to_flag_r <= 1'b0;
    else if (to_hit)
      to_flag_r <= 1'b1;
    else if (rhr_rd)
      to_flag_r <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit ready

  logic [4:0] tx_prev_r;
  logic       refill_over_r;
  logic       ier_tx_prev_r;
  logic       tx_set;
  logic       tx_flag_r;

  // Falling below the level, or emptying after a refill that stayed at or under it
  assign tx_set = ((tx_count < tx_lvl) && (tx_prev_r >= tx_lvl))
                | ((tx_count == 5'h00) && (tx_prev_r != 5'h00) && !refill_over_r)
                | (ier[IER_TX_BIT] && !ier_tx_prev_r && (tx_count == 5'h00));

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_prev_r     <= 5'h00;
      refill_over_r <= 1'b0;
      ier_tx_prev_r <= 1'b0;
    end
    else
    begin
      tx_prev_r     <= tx_count;
      ier_tx_prev_r <= ier[IER_TX_BIT];
      if (tx_count > tx_lvl)
        refill_over_r <= 1'b1;
      else if (tx_count == 5'h00)
        refill_over_r <= 1'b0;
    end

  // New event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      tx_flag_r <= 1'b0;
    else if (tx_set)
      tx_flag_r <= 1'b1;
    else if (isr_rd || txw_r)
      tx_flag_r <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Line status, modem status, software and hardware flow sources

  logic ls_prev_r;
  logic ms_prev_r;
  logic ls_set;
  logic ms_set;
  logic ls_flag_r;
  logic ms_flag_r;
  logic xs_flag_r;
  logic xs_special_r;
  logic xs_set;
  logic cts_s1_r;
  logic cts_s2_r;
  logic cts_s3_r;
  logic rts_prev_r;
  logic fl_set;
  logic fl_flag_r;

  // Outside logic presents bits 2..4 for the character at the FIFO top
  assign ls_set = (|line_status[4:1]) & ~ls_prev_r;
  assign ms_set = (|modem_status[3:0]) & ~ms_prev_r;
  assign xs_set = rx_evt.xoff | rx_evt.special;
  assign fl_set = (cts_s2_r & ~cts_s3_r & efr_r[EFR_CTS_BIT])
                | (rts_n_state & ~rts_prev_r & efr_r[EFR_RTS_BIT]);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ls_prev_r  <= 1'b0;
      ms_prev_r  <= 1'b0;
      rts_prev_r <= 1'b1;
      cts_s1_r   <= 1'b1;
      cts_s2_r   <= 1'b1;
      cts_s3_r   <= 1'b1;
    end
    else
    begin
      ls_prev_r  <= |line_status[4:1];
      ms_prev_r  <= |modem_status[3:0];
      rts_prev_r <= rts_n_state;
      cts_s1_r   <= cts_n;
      cts_s2_r   <= cts_s1_r;
      cts_s3_r   <= cts_s2_r;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ls_flag_r <= 1'b0;
    else if (ls_set)
      ls_flag_r <= 1'b1;
    else if (lsr_rd)
      ls_flag_r <= 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ms_flag_r <= 1'b0;
      fl_flag_r <= 1'b0;
    end
    else
    begin
      if (ms_set)
        ms_flag_r <= 1'b1;
      else if (msr_rd)
        ms_flag_r <= 1'b0;
      if (fl_set)
        fl_flag_r <= 1'b1;
      else if (msr_rd)
        fl_flag_r <= 1'b0;
    end

  // Remember which kind of match raised the flag to pick its clear
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      xs_flag_r    <= 1'b0;
      xs_special_r <= 1'b0;
    end
    else if (xs_set)
    begin
      xs_flag_r    <= 1'b1;
      xs_special_r <= rx_evt.special;
    end
    else if (isr_rd || (rx_evt.xon && !xs_special_r) || (rx_evt.push && xs_special_r))
      xs_flag_r <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Priority encoder

  logic ls_pend;
  logic to_pend;
  logic rx_pend;
  logic tx_pend;
  logic ms_pend;
  logic xs_pend;
  logic fl_pend;

  assign ls_pend = ls_flag_r & ier[IER_LS_BIT];
  assign to_pend = to_flag_r & ier[IER_RX_BIT];
  assign rx_pend = rx_ready_event & ier[IER_RX_BIT];
  assign tx_pend = tx_flag_r & ier[IER_TX_BIT];
  assign ms_pend = ms_flag_r & ier[IER_MS_BIT];
  assign xs_pend = xs_flag_r & ier[IER_XOFF_BIT] & efr_r[EFR_ENH_BIT];
  assign fl_pend = fl_flag_r & (ier[IER_RTS_BIT] | ier[IER_CTS_BIT])
                 & efr_r[EFR_ENH_BIT];

  always_comb
  begin
    if (ls_pend)
      isr_code = CODE_LS;
    else if (to_pend)
      isr_code = CODE_TO;
    else if (rx_pend)
      isr_code = CODE_RX;
    else if (tx_pend)
      isr_code = CODE_TX;
    else if (ms_pend)
      isr_code = CODE_MS;
    else if (xs_pend)
      isr_code = CODE_XS;
    else if (fl_pend)
      isr_code = CODE_FL;
    else
      isr_code = CODE_NONE;
  end

  assign isr_val     = {fcr_r.en, fcr_r.en, isr_code};
  assign int_pending = ~isr_code[0];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_ls_set;
    @(posedge hclk) disable iff (!hresetn)
      $rose(|line_status[4:1]) |=> ls_flag_r;
  endproperty
  a_ls_set: assert property (p_ls_set) else $error("line status flag not set");

  property p_ls_clr;
    @(posedge hclk) disable iff (!hresetn)
      (lsr_rd && !ls_set) |=> !ls_flag_r;
  endproperty
  a_ls_clr: assert property (p_ls_clr) else $error("line status flag not cleared");

  property p_to_fire;
    @(posedge hclk) disable iff (!hresetn)
      to_hit |=> to_flag_r && to_cnt_r == to_limit;
  endproperty
  a_to_fire: assert property (p_to_fire) else $error("time-out did not fire");

  property p_to_clr;
    @(posedge hclk) disable iff (!hresetn)
      rhr_rd |=> !to_flag_r && to_cnt_r == 7'h00;
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("time-out not cleared by read");

  property p_tx_clr;
    @(posedge hclk) disable iff (!hresetn)
      ((isr_rd || txw_r) && !tx_set) |=> !tx_flag_r;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("transmit ready not cleared");

  property p_msr_clr;
    @(posedge hclk) disable iff (!hresetn)
      (msr_rd && !ms_set && !fl_set) |=> !ms_flag_r && !fl_flag_r;
  endproperty
  a_msr_clr: assert property (p_msr_clr) else $error("modem read did not clear");

  property p_prio_ls;
    @(posedge hclk) disable iff (!hresetn)
      ls_pend |-> isr_code == CODE_LS && int_pending;
  endproperty
  a_prio_ls: assert property (p_prio_ls) else $error("line status not top priority");

  property p_none;
    @(posedge hclk) disable iff (!hresetn)
      !(ls_pend | to_pend | rx_pend | tx_pend | ms_pend | xs_pend | fl_pend)
        |-> isr_val[5:0] == CODE_NONE && !int_pending;
  endproperty
  a_none: assert property (p_none) else $error("idle code wrong");

  property p_isr_top;
    @(posedge hclk) disable iff (!hresetn)
      isr_rd |=> hrdata[7:6] == {2{$past(fcr_r.en)}};
  endproperty
  a_isr_top: assert property (p_isr_top) else $error("fifo status bits wrong");

  property p_fcr_ignore;
    @(posedge hclk) disable iff (!hresetn)
      (wr_now && wr_addr_r == OFS_ISR && !wdat[FCR_EN_BIT])
        |=> !fcr_r.en && $stable(fcr_r.rx_trig) && !rx_fifo_reset;
  endproperty
  a_fcr_ignore: assert property (p_fcr_ignore) else $error("fifo control not ignored");

  property p_rst_pulse;
    @(posedge hclk) disable iff (!hresetn)
      rx_fifo_reset |=> !rx_fifo_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset strobe stuck");

  c_timeout: cover property (@(posedge hclk) disable iff (!hresetn) $rose(to_flag_r));
  c_tx_ready: cover property (@(posedge hclk) disable iff (!hresetn) $rose(tx_flag_r));
  c_flow: cover property (@(posedge hclk) disable iff (!hresetn) fl_pend && isr_code == CODE_FL);
  c_xoff: cover property (@(posedge hclk) disable iff (!hresetn) xs_pend ##1 isr_rd);

endmodule : uart_irq_fifo_line_control

// [verilog/uart_irq_line_pkg.sv]
// Purpose: Shared constants and carrier types for the UART interrupt and line control block
// Assumes: AHB-Lite word registers, 8-bit register values in the low byte
// Notes:   Offsets are byte addresses on the register bus
package uart_irq_line_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;  // rx_holding_reg read, tx_holding_reg write
  localparam logic [7:0] OFS_ISR  = 8'h08;  // interrupt_status_reg read, fifo_control_reg write
  localparam logic [7:0] OFS_LCR  = 8'h0C;  // line_control_reg
  localparam logic [7:0] OFS_LSR  = 8'h14;  // line_status_reg, read only
  localparam logic [7:0] OFS_MSR  = 8'h18;  // modem_status_reg, read only
  localparam logic [7:0] OFS_EFR  = 8'h24;  // enhanced_feature_reg

  // Reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;

  // Field positions
  localparam int FCR_EN_BIT    = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam int FCR_DMA_BIT   = 3;
  localparam int EFR_ENH_BIT   = 4;
  localparam int EFR_RTS_BIT   = 6;
  localparam int EFR_CTS_BIT   = 7;
  localparam int IER_RX_BIT    = 0;
  localparam int IER_TX_BIT    = 1;
  localparam int IER_LS_BIT    = 2;
  localparam int IER_MS_BIT    = 3;
  localparam int IER_XOFF_BIT  = 5;
  localparam int IER_RTS_BIT   = 6;
  localparam int IER_CTS_BIT   = 7;

  // Interrupt status codes, bits 5..0
  localparam logic [5:0] CODE_LS   = 6'h06;
  localparam logic [5:0] CODE_TO   = 6'h0C;
  localparam logic [5:0] CODE_RX   = 6'h04;
  localparam logic [5:0] CODE_TX   = 6'h02;
  localparam logic [5:0] CODE_MS   = 6'h00;
  localparam logic [5:0] CODE_XS   = 6'h10;
  localparam logic [5:0] CODE_FL   = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;

  // FIFO trigger levels for codes 00..11
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;

  // Receive time-out: character times plus extra bit times
  localparam logic [6:0] TO_CHARS      = 7'h04;
  localparam logic [6:0] TO_EXTRA_BITS = 7'h0C;
  localparam logic [3:0] START_PLUS_5  = 4'h6;

  localparam logic [2:0] SIZE_WORD = 3'h2;

  typedef struct packed {
    logic       div_en;
    logic       brk;
    logic       force_par;
    logic       even;
    logic       par_en;
    logic       stop2;
    logic [1:0] wlen;
  } line_fmt_t;

  typedef struct packed {
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic       dma;
    logic       en;
  } fifo_ctl_t;

  typedef struct packed {
    logic push;
    logic xoff;
    logic xon;
    logic special;
  } rx_evt_t;

endpackage : uart_irq_line_pkg

// [verif/ahb_host_model.sv]
// Purpose: AHB-Lite host issuing single word transfers
// Assumes: One slave whose hreadyout is the bus hready
// Notes:   Each phase is held until hready is sampled high
`timescale 1ns/1ns
module ahb_host_model
(
  // Bus clock
  input  wire logic        hclk,
  // Slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Master drive
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic             hwrite,
  output logic [1:0]       htrans,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  ////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 8'h00;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One word transfer; read data taken at the data phase edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : xfer
endmodule : ahb_host_model

// [verif/uart_irq_fifo_line_control_bench.sv]
// Purpose: Self-checking bench for the UART interrupt and line control block
// Assumes: Host model drives the register bus
// Notes:   Edge detectors need a few cycles, so sources settle before reads
`timescale 1ns/1ns
module uart_irq_fifo_line_control_bench;
  import uart_irq_line_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_write, rx_read;
  logic rx_fifo_reset, tx_fifo_reset, int_pending;
  logic bit_tick, cts_n, rts_n_state;
  rx_evt_t rx_evt;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] haddr, rx_data, line_status, modem_status, ier, tx_data, enhanced_feature_reg;
  logic [31:0] hwdata, hrdata, d, v;
  logic [4:0] rx_count, tx_count;
  fifo_ctl_t fifo_ctl;
  line_fmt_t line_fmt;
  int mismatches, total_checks, seed, i, n, pops;

  ahb_host_model hm (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans),
    .hsize(hsize), .hwdata(hwdata));

  uart_irq_fifo_line_control uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_data(rx_data), .line_status(line_status),
    .modem_status(modem_status), .ier(ier), .rx_count(rx_count),
    .tx_count(tx_count), .bit_tick(bit_tick), .rx_evt(rx_evt), .cts_n(cts_n),
    .rts_n_state(rts_n_state), .tx_data(tx_data), .tx_write(tx_write),
    .rx_read(rx_read), .fifo_ctl(fifo_ctl), .rx_fifo_reset(rx_fifo_reset),
    .tx_fifo_reset(tx_fifo_reset), .line_fmt(line_fmt), .enhanced_feature_reg(enhanced_feature_reg),
    .int_pending(int_pending));

  ////////////////////////////////////////////////////////////////
  // Clock
  always #5 hclk = ~hclk;

  // Expected status byte: FIFO enable twice over the source code
  function automatic logic [31:0] isr_exp(input logic en, input logic [5:0] c);
    return {24'h0, en, en, c};
  endfunction : isr_exp

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] x);
    hm.xfer(1'b1, a, x, d);
  endtask : wr

  // Read, after letting source edges settle
  task rdc(input logic [7:0] a, input logic [31:0] e);
    repeat (4) @(posedge hclk);
    hm.xfer(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask : rdc

  // Interrupt line looked at mid-cycle; returns on a rising edge
  task chk_int(input logic e);
    @(negedge hclk);
    chk({31'h0, int_pending}, {31'h0, e});
    @(posedge hclk);
  endtask : chk_int

  // Receive event of one clock, then a quiet clock so pulses never merge
  task pulse(input logic [3:0] e);
    rx_evt <= e;
    @(posedge hclk);
    rx_evt <= 4'h0;
    @(posedge hclk);
  endtask : pulse

  // Bit-time pulses, one clock wide with a gap
  task ticks(input int k);
    repeat (k)
    begin
      bit_tick <= 1'b1;
      @(posedge hclk);
      bit_tick <= 1'b0;
      @(posedge hclk);
    end
  endtask : ticks

  // Four frames (start, 5 + code data bits, parity, stops) plus extra bits; 1.5 stops as two
  function automatic int to_ticks(input logic [7:0] l);
    return TO_CHARS * (7 + l[1:0] + l[3] + l[2]) + TO_EXTRA_BITS;
  endfunction : to_ticks

  // Receive pops seen by the outside FIFO
  always @(posedge hclk)
    if (rx_read === 1'b1)
      pops++;

  task give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////
  // Watchdog cuts a hang short
  initial
  begin
    #200000;
    mismatches++;
    give_verdict;
  end

  // Main sequence
  initial
  begin
    seed = 98;
    hclk = 0;
    hresetn = 0;
    {rx_data, line_status, modem_status, ier} = 32'h0;
    {rx_count, tx_count} = 10'h0;
    {bit_tick, cts_n, rts_n_state} = 3'h3;
    rx_evt = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFS_LCR, {24'h0, LCR_RST});
    rdc(OFS_ISR, isr_exp(1'b0, CODE_NONE));
    $display("reset test done");
    // Format: 0x1F corner (bits 4..0 set) first, then random values
    for (i = 0; i < 5; i++)
    begin
      v = (i == 0) ? 32'h1F : $random(seed);
      wr(OFS_LCR, {24'h0, v[7:0]});
      rdc(OFS_LCR, {24'h0, v[7:0]});
      chk({24'h0, line_fmt}, {24'h0, v[7:0]});
    end
    $display("line format test done");
    wr(OFS_ISR, 32'hC6);
    #1;
    chk({26'h0, fifo_ctl}, 32'h0);
    wr(OFS_ISR, 32'hF7);
    #1;
    chk({30'h0, rx_fifo_reset, tx_fifo_reset}, 32'h3);
    chk({26'h0, fifo_ctl}, 32'h31);
    wr(OFS_ISR, 32'h00);
    rdc(OFS_ISR, isr_exp(1'b0, CODE_NONE));
    wr(OFS_ISR, 32'h01);
    $display("fifo control test done");
    // Sources stacked and cleared one by one
    ier <= 8'hFF;
    rdc(OFS_ISR, isr_exp(1'b1, CODE_TX));
    rdc(OFS_ISR, isr_exp(1'b1, CODE_NONE));
    rx_count <= 5'h01;
    rdc(OFS_ISR, isr_exp(1'b1, CODE_RX));
    line_status <= 8'h02 << ($unsigned($random(seed)) % 4);
    rdc(OFS_ISR, isr_exp(1'b1, CODE_LS));
    rdc(OFS_LSR, {24'h0, line_status});
    line_status <= 8'h00;
    rdc(OFS_ISR, isr_exp(1'b1, CODE_RX));
    rx_count <= 5'h00;
    modem_status <= 8'h01 << ($unsigned($random(seed)) % 4);
    rdc(OFS_ISR, isr_exp(1'b1, CODE_MS));
    rdc(OFS_MSR, {24'h0, modem_status});
    modem_status <= 8'h00;
    rdc(OFS_ISR, isr_exp(1'b1, CODE_NONE));
    $display("interrupt test done");
    // Time-out, random format: one tick short, restarted by a push, then fired
    v = $random(seed);
    wr(OFS_LCR, {24'h0, v[7:0]});
    n = to_ticks(v[7:0]);
    rx_count <= 5'h01;
    ticks(n - 1);
    pulse(4'h8);
    ticks(n - 1);
    rdc(OFS_ISR, isr_exp(1'b1, CODE_RX));
    ticks(1);
    rdc(OFS_ISR, isr_exp(1'b1, CODE_TO));
    rdc(OFS_DATA, {24'h0, rx_data});
    rdc(OFS_ISR, isr_exp(1'b1, CODE_RX));
    $display("time-out test done");
    // Enhanced mode: transmit trigger, Xoff, special character, flow change
    wr(OFS_EFR, 32'hD0);
    rdc(OFS_EFR, 32'hD0);
    chk({24'h0, enhanced_feature_reg}, 32'hD0);
    wr(OFS_ISR, 32'h31);
    rx_count <= 5'h00;
    @(negedge hclk);
    chk({26'h0, fifo_ctl}, 32'h0D);
    @(posedge hclk);
    pulse(4'h4);
    rdc(OFS_ISR, isr_exp(1'b1, CODE_XS));
    chk_int(1'b0);
    pulse(4'h4);
    chk_int(1'b1);
    pulse(4'h2);
    chk_int(1'b0);
    pulse(4'h1);
    chk_int(1'b1);
    pulse(4'h8);
    chk_int(1'b0);
    cts_n <= 1'b0;
    repeat (4) @(posedge hclk);
    cts_n <= 1'b1;
    rdc(OFS_ISR, isr_exp(1'b1, CODE_FL));
    rdc(OFS_MSR, 32'h0);
    rdc(OFS_ISR, isr_exp(1'b1, CODE_NONE));
    rts_n_state <= 1'b0;
    @(posedge hclk);
    rts_n_state <= 1'b1;
    @(posedge hclk);
    chk_int(1'b1);
    rdc(OFS_MSR, 32'h0);
    chk_int(1'b0);
    $display("enhanced test done");
    v = $random(seed);
    rx_data <= v[7:0];
    rdc(OFS_DATA, {24'h0, v[7:0]});
    rdc(8'h30, 32'h0);
    // Transmit level crossed from above, then cleared by a holding write
    tx_count <= 5'h0F;
    @(posedge hclk);
    tx_count <= 5'h0D;
    @(posedge hclk);
    chk_int(1'b1);
    v = $random(seed);
    wr(OFS_DATA, v);
    #1;
    chk({23'h0, tx_write, tx_data}, {23'h1, v[7:0]});
    @(posedge hclk);
    chk_int(1'b0);
    chk(pops, 32'h2);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    $display("data path test done");
    give_verdict;
  end
endmodule : uart_irq_fifo_line_control_bench
